// ---- src/eirq_pkg.sv ----
package eirq_pkg;

  // ----------------------------------------------------------------------------
  // Register addresses on the serial control port's internal register side.
  // ----------------------------------------------------------------------------
  localparam logic [7:0] EIRQ_ADDR_MASK_A   = 8'h03;
  localparam logic [7:0] EIRQ_ADDR_MASK_B   = 8'h04;
  localparam logic [7:0] EIRQ_ADDR_FLAGS_A  = 8'h05;
  localparam logic [7:0] EIRQ_ADDR_FLAGS_B  = 8'h06;
  localparam logic [7:0] EIRQ_ADDR_ROUTE_A  = 8'h07;
  localparam logic [7:0] EIRQ_ADDR_ROUTE_B  = 8'h08;
  localparam logic [7:0] EIRQ_ADDR_FRAMING  = 8'h09;
  localparam logic [7:0] EIRQ_ADDR_DLL_CTRL = 8'h0a;
  localparam logic [7:0] EIRQ_ADDR_WARN_CLR = 8'h0b;

  // ----------------------------------------------------------------------------
  // Reset values.
  // ----------------------------------------------------------------------------
  localparam logic [7:0] EIRQ_RST_MASK     = 8'h00;
  localparam logic [7:0] EIRQ_RST_ROUTE    = 8'h00;
  localparam logic [7:0] EIRQ_RST_FRAMING  = 8'h00;
  localparam logic [7:0] EIRQ_RST_DLL_CTRL = 8'h40;
  localparam logic [7:0] EIRQ_RST_WARN_CLR = 8'h39;
  localparam logic [7:0] EIRQ_RD_NONE      = 8'h00;

  // ----------------------------------------------------------------------------
  // Implemented bits of the event groups; all other bits read as zero.
  // ----------------------------------------------------------------------------
  localparam logic [7:0] EIRQ_IMPL_A = 8'h7c;
  localparam logic [7:0] EIRQ_IMPL_B = 8'hf6;

  // ----------------------------------------------------------------------------
  // Field positions.
  // ----------------------------------------------------------------------------
  localparam int EIRQ_BIT_SYNC_LOST    = 6;
  localparam int EIRQ_BIT_SYNC_LOCKED  = 5;
  localparam int EIRQ_BIT_SYNC_DONE    = 4;
  localparam int EIRQ_BIT_PLL_LOST     = 3;
  localparam int EIRQ_BIT_PLL_LOCKED   = 2;
  localparam int EIRQ_BIT_PARITY_FAIL  = 7;
  localparam int EIRQ_BIT_MISMATCH     = 6;
  localparam int EIRQ_BIT_DLL_WARNING  = 5;
  localparam int EIRQ_BIT_DLL_LOCKED   = 4;
  localparam int EIRQ_BIT_UNDERFLOW    = 2;
  localparam int EIRQ_BIT_OVERFLOW     = 1;
  localparam int EIRQ_BIT_PARITY_USE   = 5;
  localparam int EIRQ_BIT_FRAME_USE    = 4;
  localparam int EIRQ_FPF_HI           = 1;
  localparam int EIRQ_FPF_LO           = 0;
  localparam int EIRQ_BIT_DLL_EN       = 7;
  localparam int EIRQ_BIT_DUTY_CORR    = 6;
  localparam int EIRQ_BIT_PHASE_SIGN   = 3;
  localparam int EIRQ_BIT_CLEAR_WARN   = 7;

  // Frame pin function codes.
  localparam logic [1:0] EIRQ_FPF_NONE   = 2'h0;
  localparam logic [1:0] EIRQ_FPF_PARITY = 2'h1;
  localparam logic [1:0] EIRQ_FPF_FRAME  = 2'h2;

  // Locked phase is 90 degrees plus n steps of 11.25 degrees; 90 degrees is
  // eight steps, so the step count handed to the DLL is centred on eight.
  localparam logic [3:0] EIRQ_PHASE_CENTRE = 4'h8;

  // ----------------------------------------------------------------------------
  // Carriers.
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } eirq_reg_req_t;

  typedef struct packed {
    logic sync_lost;
    logic sync_locked;
    logic sync_done;
    logic pll_lost;
    logic pll_locked;
    logic parity_fail;
    logic pattern_mismatch;
    logic dll_warning;
    logic dll_locked;
    logic fifo_underflow;
    logic fifo_overflow;
  } eirq_events_t;

  typedef struct packed {
    logic near_either_end;
    logic at_start;
    logic at_end;
  } eirq_dll_warn_t;

endpackage

// ---- src/eirq_sticky.sv ----
module eirq_sticky
  import eirq_pkg::*;
#(
  parameter int WIDTH = 8
)
(
  input  wire logic             core_clk_in,
  input  wire logic             reset_n_in,
  input  wire logic [WIDTH-1:0] set_in,
  input  wire logic [WIDTH-1:0] clr_in,
  output logic      [WIDTH-1:0] q_out
);

  logic [WIDTH-1:0] q_reg;
  logic [WIDTH-1:0] q_next;

  // ----------------------------------------------------------------------------
  // Sticky bits: a set in the same cycle as a clear wins, so no event is lost.
  // ----------------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      always_comb
      begin
        q_next[i] = set_in[i] | (q_reg[i] & ~clr_in[i]);
      end
    end
  endgenerate

  always_ff @(posedge core_clk_in)
  begin
    if (!reset_n_in)
      q_reg <= '0;
    else
      q_reg <= q_next;
  end

  assign q_out = q_reg;

endmodule

// ---- src/eirq_unit.sv ----
// Operation
// [RULE1] Mask bits for alignment lost/locked/done (6..4), PLL lost/locked (3,2), reset 0.
// [RULE2] Second mask group: parity 7, mismatch 6, DLL warn 5, lock 4, FIFO 2, 1.
// [RULE3] Flag bits 6, 5, 4 set on alignment lost, locked and done.
// [RULE4] Flag bit 3 sets on PLL lock loss, bit 2 on PLL lock.
// [RULE5] Second flag bit 7 sets on input parity failure.
// [RULE6] Second flag bit 6 sets on sample pattern mismatch.
// [RULE7] Second flag bit 5 sets on DLL warning, bit 4 on DLL lock.
// [RULE8] Second flag bit 2 sets when FIFO read pointer meets write pointer.
// [RULE9] Second flag bit 1 sets when FIFO write pointer meets read pointer.
// [RULE10] Route bit per event: 0 sends it to pin A, 1 to pin B.
// [RULE11] Software sets parity usage bit 5 whenever input parity is checked.
// [RULE12] Software sets frame usage bit 4 whenever the frame input is used.
// [RULE13] Frame pin field: 0 nothing, 1 parity, 2 frame, 3 reserved.
// [RULE14] Enabled DLL locks at 90 plus n times 11.25 degrees, n signed-magnitude.
// [RULE15] Duty cycle correction on while control bit 6 is 1, its reset value.
// [RULE16] Writing 1 to warning-clear bit 7 clears the three DLL warning bits.
// [RULE17] Software keeps reserved warning-clear bits 6:0 at their default value.
// [RULE18] Warning bits: near either end, at beginning, at end of delay line.
// [RULE19] Each pin is active while any event routed to it is flagged and enabled.
// [RULE20] Event flags stay set until device reset.
module eirq_unit
  import eirq_pkg::*;
(
  input  wire logic           core_clk_in,
  input  wire logic           reset_n_in,
  input  wire eirq_reg_req_t  reg_req_in,
  input  wire eirq_events_t   events_in,
  input  wire eirq_dll_warn_t dll_warn_in,
  output logic [7:0]          reg_rdata_out,
  output logic                reg_rvalid_out,
  output logic                interrupt_out_a,
  output logic                interrupt_out_b,
  output logic                parity_in_use_out,
  output logic                frame_in_use_out,
  output logic                pin_as_parity_out,
  output logic                pin_as_frame_out,
  output logic                dll_enable_out,
  output logic [3:0]          dll_phase_steps_out,
  output logic                duty_correction_out,
  output eirq_dll_warn_t      dll_warn_status_out
);

  // ----------------------------------------------------------------------------
  // Register state.
  // ----------------------------------------------------------------------------
  logic [7:0] mask_a_reg;
  logic [7:0] mask_a_next;
  logic [7:0] mask_b_reg;
  logic [7:0] mask_b_next;
  logic [7:0] route_a_reg;
  logic [7:0] route_a_next;
  logic [7:0] route_b_reg;
  logic [7:0] route_b_next;
  logic [7:0] framing_reg;
  logic [7:0] framing_next;
  logic [7:0] dll_ctrl_reg;
  logic [7:0] dll_ctrl_next;
  logic [7:0] warn_clr_reg;
  logic [7:0] warn_clr_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic       rvalid_reg;
  logic       rvalid_next;
  logic       irq_a_reg;
  logic       irq_a_next;
  logic       irq_b_reg;
  logic       irq_b_next;
  logic       pin_par_reg;
  logic       pin_par_next;
  logic       pin_frm_reg;
  logic       pin_frm_next;
  logic [3:0] phase_reg;
  logic [3:0] phase_next;

  logic [15:0] flag_set;
  logic [15:0] flag_q;
  logic [7:0]  flags_a;
  logic [7:0]  flags_b;
  logic [2:0]  warn_clr_pulse;
  logic [2:0]  warn_q;
  logic [7:0]  pend_a;
  logic [7:0]  pend_b;

  function automatic logic is_write(input eirq_reg_req_t req, input logic [7:0] addr);
    is_write = req.wr && (req.addr == addr);
  endfunction

  // Signed-magnitude offset around the 90 degree centre, in 11.25 degree steps.
  function automatic logic [3:0] phase_steps(input logic [3:0] n);
    phase_steps = n[EIRQ_BIT_PHASE_SIGN] ? EIRQ_PHASE_CENTRE - {1'b0, n[2:0]}
                                         : EIRQ_PHASE_CENTRE + {1'b0, n[2:0]};
  endfunction

  // ----------------------------------------------------------------------------
  // Event flags.
  // ----------------------------------------------------------------------------
  always_comb
  begin
    flag_set = '0;
    flag_set[8 + EIRQ_BIT_SYNC_LOST]   = events_in.sync_lost;         // [RULE3]
    flag_set[8 + EIRQ_BIT_SYNC_LOCKED] = events_in.sync_locked;       // [RULE3]
    flag_set[8 + EIRQ_BIT_SYNC_DONE]   = events_in.sync_done;         // [RULE3]
    flag_set[8 + EIRQ_BIT_PLL_LOST]    = events_in.pll_lost;          // [RULE4]
    flag_set[8 + EIRQ_BIT_PLL_LOCKED]  = events_in.pll_locked;        // [RULE4]
    flag_set[EIRQ_BIT_PARITY_FAIL]     = events_in.parity_fail;       // [RULE5]
    flag_set[EIRQ_BIT_MISMATCH]        = events_in.pattern_mismatch;  // [RULE6]
    flag_set[EIRQ_BIT_DLL_WARNING]     = events_in.dll_warning;       // [RULE7]
    flag_set[EIRQ_BIT_DLL_LOCKED]      = events_in.dll_locked;        // [RULE7]
    flag_set[EIRQ_BIT_UNDERFLOW]       = events_in.fifo_underflow;    // [RULE8]
    flag_set[EIRQ_BIT_OVERFLOW]        = events_in.fifo_overflow;     // [RULE9]
  end

  // No software clear exists for the flags, so they hold until reset.
  eirq_sticky #(
    .WIDTH (16)
  ) u_flags (
    .core_clk_in (core_clk_in),
    .reset_n_in  (reset_n_in),
    .set_in      (flag_set),
    .clr_in      (16'h0000),  // [RULE20]
    .q_out       (flag_q)
  );

  assign flags_a = flag_q[15:8] & EIRQ_IMPL_A;
  assign flags_b = flag_q[7:0] & EIRQ_IMPL_B;

  // ----------------------------------------------------------------------------
  // Receiver DLL warning status, cleared by the warning-clear control.
  // ----------------------------------------------------------------------------
  assign warn_clr_pulse = {3{is_write(reg_req_in, EIRQ_ADDR_WARN_CLR)
                             && reg_req_in.wdata[EIRQ_BIT_CLEAR_WARN]}};  // [RULE16]

  eirq_sticky #(
    .WIDTH (3)
  ) u_warn (
    .core_clk_in (core_clk_in),
    .reset_n_in  (reset_n_in),
    .set_in      (dll_warn_in),  // [RULE18]
    .clr_in      (warn_clr_pulse),
    .q_out       (warn_q)
  );

  assign dll_warn_status_out = warn_q;

  // ----------------------------------------------------------------------------
  // Register file and derived outputs.
  // ----------------------------------------------------------------------------
  assign pend_a = flags_a & mask_a_reg;
  assign pend_b = flags_b & mask_b_reg;

  always_comb
  begin
    mask_a_next   = mask_a_reg;
    mask_b_next   = mask_b_reg;
    route_a_next  = route_a_reg;
    route_b_next  = route_b_reg;
    framing_next  = framing_reg;
    dll_ctrl_next = dll_ctrl_reg;
    warn_clr_next = warn_clr_reg;
    if (is_write(reg_req_in, EIRQ_ADDR_MASK_A))
      mask_a_next = reg_req_in.wdata & EIRQ_IMPL_A;    // [RULE1]
    if (is_write(reg_req_in, EIRQ_ADDR_MASK_B))
      mask_b_next = reg_req_in.wdata & EIRQ_IMPL_B;    // [RULE2]
    if (is_write(reg_req_in, EIRQ_ADDR_ROUTE_A))
      route_a_next = reg_req_in.wdata & EIRQ_IMPL_A;   // [RULE10]
    if (is_write(reg_req_in, EIRQ_ADDR_ROUTE_B))
      route_b_next = reg_req_in.wdata & EIRQ_IMPL_B;   // [RULE10]
    if (is_write(reg_req_in, EIRQ_ADDR_FRAMING))
      framing_next = reg_req_in.wdata & 8'h33;
    if (is_write(reg_req_in, EIRQ_ADDR_DLL_CTRL))
      dll_ctrl_next = reg_req_in.wdata & 8'hcf;
    if (is_write(reg_req_in, EIRQ_ADDR_WARN_CLR))
      warn_clr_next = reg_req_in.wdata;
    // Decoded outputs follow the stored fields so both change on one edge.
    pin_par_next = framing_next[EIRQ_FPF_HI:EIRQ_FPF_LO] == EIRQ_FPF_PARITY;  // [RULE13]
    pin_frm_next = framing_next[EIRQ_FPF_HI:EIRQ_FPF_LO] == EIRQ_FPF_FRAME;   // [RULE13]
    phase_next   = phase_steps(dll_ctrl_next[3:0]);                          // [RULE14]
    irq_a_next   = |(pend_a & ~route_a_reg) | |(pend_b & ~route_b_reg);      // [RULE19]
    irq_b_next   = |(pend_a & route_a_reg) | |(pend_b & route_b_reg);        // [RULE19]
    rvalid_next  = reg_req_in.rd;
    rdata_next   = rdata_reg;
    if (reg_req_in.rd)
    begin
      case (reg_req_in.addr)
        EIRQ_ADDR_MASK_A:   rdata_next = mask_a_reg;
        EIRQ_ADDR_MASK_B:   rdata_next = mask_b_reg;
        EIRQ_ADDR_FLAGS_A:  rdata_next = flags_a;
        EIRQ_ADDR_FLAGS_B:  rdata_next = flags_b;
        EIRQ_ADDR_ROUTE_A:  rdata_next = route_a_reg;
        EIRQ_ADDR_ROUTE_B:  rdata_next = route_b_reg;
        EIRQ_ADDR_FRAMING:  rdata_next = framing_reg;
        EIRQ_ADDR_DLL_CTRL: rdata_next = dll_ctrl_reg;
        EIRQ_ADDR_WARN_CLR: rdata_next = warn_clr_reg;
        default:            rdata_next = EIRQ_RD_NONE;
      endcase
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!reset_n_in)
    begin
      mask_a_reg   <= EIRQ_RST_MASK;
      mask_b_reg   <= EIRQ_RST_MASK;
      route_a_reg  <= EIRQ_RST_ROUTE;
      route_b_reg  <= EIRQ_RST_ROUTE;
      framing_reg  <= EIRQ_RST_FRAMING;
      dll_ctrl_reg <= EIRQ_RST_DLL_CTRL;  // [RULE15]
      warn_clr_reg <= EIRQ_RST_WARN_CLR;
      rdata_reg    <= EIRQ_RD_NONE;
      rvalid_reg   <= 1'b0;
      irq_a_reg    <= 1'b0;
      irq_b_reg    <= 1'b0;
      pin_par_reg  <= 1'b0;
      pin_frm_reg  <= 1'b0;
      phase_reg    <= EIRQ_PHASE_CENTRE;
    end
    else
    begin
      mask_a_reg   <= mask_a_next;
      mask_b_reg   <= mask_b_next;
      route_a_reg  <= route_a_next;
      route_b_reg  <= route_b_next;
      framing_reg  <= framing_next;
      dll_ctrl_reg <= dll_ctrl_next;
      warn_clr_reg <= warn_clr_next;
      rdata_reg    <= rdata_next;
      rvalid_reg   <= rvalid_next;
      irq_a_reg    <= irq_a_next;
      irq_b_reg    <= irq_b_next;
      pin_par_reg  <= pin_par_next;
      pin_frm_reg  <= pin_frm_next;
      phase_reg    <= phase_next;
    end
  end

  assign reg_rdata_out       = rdata_reg;
  assign reg_rvalid_out      = rvalid_reg;
  assign interrupt_out_a     = irq_a_reg;
  assign interrupt_out_b     = irq_b_reg;
  assign parity_in_use_out   = framing_reg[EIRQ_BIT_PARITY_USE];
  assign frame_in_use_out    = framing_reg[EIRQ_BIT_FRAME_USE];
  assign pin_as_parity_out   = pin_par_reg;
  assign pin_as_frame_out    = pin_frm_reg;
  assign dll_enable_out      = dll_ctrl_reg[EIRQ_BIT_DLL_EN];
  assign dll_phase_steps_out = phase_reg;
  assign duty_correction_out = dll_ctrl_reg[EIRQ_BIT_DUTY_CORR];

  // ----------------------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!reset_n_in);

  a_mask_a_write: assert property ( // [RULE1]
    is_write(reg_req_in, EIRQ_ADDR_MASK_A) |=> mask_a_reg == ($past(reg_req_in.wdata) & 8'h7c))
    else $error("first mask group did not take the written value");

  a_mask_b_write: assert property ( // [RULE2]
    is_write(reg_req_in, EIRQ_ADDR_MASK_B) |=> mask_b_reg == ($past(reg_req_in.wdata) & 8'hf6))
    else $error("second mask group did not take the written value");

  a_align_flags: assert property ( // [RULE3]
    (events_in.sync_lost |=> flags_a[6]) and (events_in.sync_locked |=> flags_a[5])
    and (events_in.sync_done |=> flags_a[4]))
    else $error("alignment flags not set");

  a_flags_readback: assert property ( // [RULE3]
    reg_req_in.rd && reg_req_in.addr == EIRQ_ADDR_FLAGS_A |=> reg_rdata_out == $past(flags_a))
    else $error("first flag group not read back");

  a_pll_flags: assert property ( // [RULE4]
    (events_in.pll_lost |=> flags_a[3]) and (events_in.pll_locked |=> flags_a[2]))
    else $error("PLL flags not set");

  a_parity_flag: assert property ( // [RULE5]
    events_in.parity_fail |=> flags_b[7])
    else $error("parity failure flag not set");

  a_mismatch_flag: assert property ( // [RULE6]
    events_in.pattern_mismatch |=> flags_b[6])
    else $error("pattern mismatch flag not set");

  a_dll_flags: assert property ( // [RULE7]
    (events_in.dll_warning |=> flags_b[5]) and (events_in.dll_locked |=> flags_b[4]))
    else $error("DLL flags not set");

  a_fifo_flags: assert property ( // [RULE8] [RULE9]
    events_in.fifo_underflow || events_in.fifo_overflow
    |=> flags_b[2] == $past(flag_q[2] | events_in.fifo_underflow)
        && flags_b[1] == $past(flag_q[1] | events_in.fifo_overflow))
    else $error("FIFO flags not set");

  a_irq_route: assert property ( // [RULE10] [RULE19]
    ##1 (interrupt_out_a == $past(|(pend_a & ~route_a_reg) || |(pend_b & ~route_b_reg)))
        && (interrupt_out_b == $past(|(pend_a & route_a_reg) || |(pend_b & route_b_reg))))
    else $error("interrupt pins disagree with flags, masks and routes");

  a_pin_decode: assert property ( // [RULE13]
    (pin_as_parity_out == (framing_reg[1:0] == 2'h1))
    && (pin_as_frame_out == (framing_reg[1:0] == 2'h2)))
    else $error("frame pin function decoded wrongly");

  a_phase_steps: assert property ( // [RULE14]
    dll_phase_steps_out == (dll_ctrl_reg[3] ? 4'h8 - {1'b0, dll_ctrl_reg[2:0]}
                                            : 4'h8 + {1'b0, dll_ctrl_reg[2:0]}))
    else $error("DLL phase step count wrong");

  a_duty_reset: assert property ( // [RULE15]
    $rose(reset_n_in) |-> duty_correction_out)
    else $error("duty correction not on after reset");

  a_warn_clear: assert property ( // [RULE16] [RULE18]
    warn_clr_pulse[0] && dll_warn_in == 3'h0 |=> dll_warn_status_out == 3'h0)
    else $error("DLL warnings not cleared");

  a_flags_sticky: assert property ( // [RULE20]
    ##1 ((flag_q & $past(flag_q)) == $past(flag_q)))
    else $error("an event flag cleared without reset");

  c_irq_a: cover property ($rose(interrupt_out_a));
  c_irq_b: cover property ($rose(interrupt_out_b));
  c_warn_clear: cover property (warn_q != 3'h0 ##1 warn_clr_pulse[0] ##1 warn_q == 3'h0);
  c_flag_read: cover property (reg_rvalid_out && reg_rdata_out != 8'h00);

endmodule

// ---- test/eirq_irq_host.sv ----
module eirq_irq_host
(
  input  wire logic       core_clk_in,
  input  wire logic       reset_n_in,
  input  wire logic       irq_a_in,
  input  wire logic       irq_b_in,
  output logic      [7:0] rises_a_out,
  output logic      [7:0] rises_b_out
);
  timeunit 1ns;
  timeprecision 1ns;

  logic prev_a_reg;
  logic prev_b_reg;

  // A host services each assertion once, so a level line held high counts one request.
  always_ff @(posedge core_clk_in)
  begin
    if (!reset_n_in)
    begin
      prev_a_reg  <= 1'b0;
      prev_b_reg  <= 1'b0;
      rises_a_out <= 8'h00;
      rises_b_out <= 8'h00;
    end
    else
    begin
      prev_a_reg <= irq_a_in;
      prev_b_reg <= irq_b_in;
      if (irq_a_in && !prev_a_reg)
        rises_a_out <= rises_a_out + 8'h01;
      if (irq_b_in && !prev_b_reg)
        rises_b_out <= rises_b_out + 8'h01;
    end
  end
endmodule

// ---- test/test_event_irq_routing_and_rx_dll_ctrl.sv ----
module test_event_irq_routing_and_rx_dll_ctrl
  import eirq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int POS [11] = '{EIRQ_BIT_OVERFLOW, EIRQ_BIT_UNDERFLOW, EIRQ_BIT_DLL_LOCKED,
    EIRQ_BIT_DLL_WARNING, EIRQ_BIT_MISMATCH, EIRQ_BIT_PARITY_FAIL, EIRQ_BIT_PLL_LOCKED,
    EIRQ_BIT_PLL_LOST, EIRQ_BIT_SYNC_DONE, EIRQ_BIT_SYNC_LOCKED, EIRQ_BIT_SYNC_LOST};

  logic           core_clk_in = 1'b0;
  logic           reset_n_in  = 1'b0;
  logic           host_rst_n  = 1'b0;
  eirq_reg_req_t  req         = '0;
  eirq_events_t   ev          = '0;
  eirq_dll_warn_t warn        = '0;
  logic [7:0]     rdata;
  logic           rvalid;
  logic           irq_a;
  logic           irq_b;
  logic           par_use;
  logic           frm_use;
  logic           as_par;
  logic           as_frm;
  logic           dll_en;
  logic [3:0]     steps;
  logic           duty;
  eirq_dll_warn_t warn_st;
  logic [7:0]     rises_a;
  logic [7:0]     rises_b;
  logic [7:0]     exp_q [$];
  int             err_total  = 0;
  int             n_compared = 0;
  int             cycles     = 0;
  int             cnt_a      = 0;
  int             cnt_b      = 0;
  logic [7:0]     v;
  logic [7:0]     ad;
  logic           r;
  logic [2:0]     w;

  eirq_unit i_eirq_unit (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
    .reg_req_in(req), .events_in(ev), .dll_warn_in(warn), .reg_rdata_out(rdata),
    .reg_rvalid_out(rvalid), .interrupt_out_a(irq_a), .interrupt_out_b(irq_b),
    .parity_in_use_out(par_use), .frame_in_use_out(frm_use), .pin_as_parity_out(as_par),
    .pin_as_frame_out(as_frm), .dll_enable_out(dll_en), .dll_phase_steps_out(steps),
    .duty_correction_out(duty), .dll_warn_status_out(warn_st));

  eirq_irq_host i_eirq_irq_host (.core_clk_in(core_clk_in), .reset_n_in(host_rst_n),
    .irq_a_in(irq_a), .irq_b_in(irq_b), .rises_a_out(rises_a), .rises_b_out(rises_b));

  initial
  begin
    forever #4 core_clk_in = ~core_clk_in;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    req <= '{1'b1, 1'b0, a, d};
    @(posedge core_clk_in);
    req <= '0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk_in);
    req <= '{1'b0, 1'b1, a, 8'h00};
    exp_q.push_back(exp);
    @(posedge core_clk_in);
    req <= '0;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask

  task automatic do_reset(input int n);
    @(posedge core_clk_in);
    reset_n_in <= 1'b0;
    repeat (n) @(posedge core_clk_in);
    reset_n_in <= 1'b1;
  endtask

  // --------------------------------------------------------------------------
  // Read data is judged against the oldest outstanding expectation.
  // --------------------------------------------------------------------------
  always @(posedge core_clk_in)
  begin
    if (rvalid === 1'b1)
    begin
      if (exp_q.size() == 0)
        check(rdata, 8'hxx);
      else
        check(rdata, exp_q.pop_front());
    end
  end

  always @(posedge core_clk_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_total++;
      summarize();
    end
  end

  initial
  begin
    void'($urandom(32'ha0a8194a));
    do_reset(16);
    host_rst_n <= 1'b1;
    settle(1);
    check(duty, 1'b1);
    check(steps, EIRQ_PHASE_CENTRE);
    check({irq_a, irq_b, dll_en, as_par, as_frm}, 8'h00);
    for (int k = 3; k <= 11; k++)
      rd(k[7:0], k == 10 ? EIRQ_RST_DLL_CTRL : (k == 11 ? EIRQ_RST_WARN_CLR : 8'h00));
    rd(8'h3f, EIRQ_RD_NONE);
    wr(EIRQ_ADDR_MASK_A, 8'hff);
    wr(EIRQ_ADDR_MASK_B, 8'hff);
    wr(EIRQ_ADDR_FLAGS_B, 8'hff);
    rd(EIRQ_ADDR_MASK_A, EIRQ_IMPL_A);
    rd(EIRQ_ADDR_MASK_B, EIRQ_IMPL_B);
    rd(EIRQ_ADDR_FLAGS_B, 8'h00);
    // ------------------------------------------------------------------------
    // Every event alone: flag, pin chosen by route, mask gating, stickiness.
    // ------------------------------------------------------------------------
    for (int i = 0; i < 11; i++)
    begin
      do_reset(2);
      ad = i < 6 ? EIRQ_ADDR_MASK_B : EIRQ_ADDR_MASK_A;
      r = $urandom_range(0, 1);
      v = 8'h01 << POS[i];
      wr(ad, v);
      wr(ad + 8'h04, r ? v : 8'h00);
      @(posedge core_clk_in);
      ev <= eirq_events_t'(11'h001 << i);
      @(posedge core_clk_in);
      ev <= '0;
      settle(1);
      check({irq_a, irq_b}, r ? 8'h01 : 8'h02);
      if (r)
        cnt_b++;
      else
        cnt_a++;
      wr(ad, 8'h00);
      settle(1);
      check({irq_a, irq_b}, 8'h00);
      rd(ad + 8'h02, v);
    end
    check(rises_a, cnt_a[7:0]);
    check(rises_b, cnt_b[7:0]);
    // Usage bits follow the pin function, as controlling software must keep them.
    for (int c = 0; c < 4; c++)
    begin
      v = {2'b00, c == 1, c == 2, 2'b00, c[1:0]};
      wr(EIRQ_ADDR_FRAMING, v);
      settle(2);
      check({par_use, frm_use}, {6'h00, v[5:4]});
      check({as_par, as_frm}, {6'h00, c == 1, c == 2});
      rd(EIRQ_ADDR_FRAMING, v);
    end
    for (int k = 0; k < 6; k++)
    begin
      v = k == 0 ? 8'h08 : (k == 1 ? 8'h0f : (k == 2 ? 8'h87 : $urandom));
      wr(EIRQ_ADDR_DLL_CTRL, v);
      settle(2);
      check({dll_en, duty}, {6'h00, v[7:6]});
      check(steps, v[3] ? 8'h08 - v[2:0] : 8'h08 + v[2:0]);
      rd(EIRQ_ADDR_DLL_CTRL, v & 8'hcf);
    end
    for (int k = 0; k < 3; k++)
    begin
      w = $urandom_range(1, 7);
      @(posedge core_clk_in);
      warn <= eirq_dll_warn_t'(w);
      @(posedge core_clk_in);
      warn <= '0;
      settle(1);
      check(warn_st, w);
      wr(EIRQ_ADDR_WARN_CLR, EIRQ_RST_WARN_CLR);
      settle(1);
      check(warn_st, w);
      wr(EIRQ_ADDR_WARN_CLR, 8'h80 | EIRQ_RST_WARN_CLR);
      settle(1);
      check(warn_st, 8'h00);
      rd(EIRQ_ADDR_WARN_CLR, 8'hb9);
    end
    settle(4);
    check(exp_q.size(), 8'h00);
    summarize();
  end
endmodule
